// file: rtl/rtcs_refresh_top.sv
// Refresh interval timer, refresh counter and memory select decoders.
//
// What this block does
// - Overflow flag set on limit pass; 1-writes ignored.
// - Overflow interrupt only while its enable set.
// - Limit select: 0 means 1024, 1 means 512.
// - Eight-bit interval counter on selected clock.
// - Counter equals constant: set flag, clear counter.
// - Interval counter cleared only by power-on reset.
// - Compare match starts refresh when auto-refresh enabled.
// - Constant register cleared only at power-on.
// - Ten-bit refresh count; overflow sets flag, clears.
// - Refresh count cleared only by power-on reset.
// - Byte-key registers need A5 in upper byte.
// - Refresh count needs six-bit key 101001.
// - Undefined bits of refresh registers read zero.
// - Select control registers cleared at power-on only.
// - Bit 6 picks area 0 or area 2.
// - Bits 5..4 pick 32 to 256 Mbit.
// - Bits 3..0 give window start address 25..22.
// - Eight identical select registers, one pin each.
// - Select register bits 15..7 read zero.
// - Clock select 000 stops, else divides bus clock.
// - Match flag clears on refresh after zero written.
// - Compare interrupt only while its enable set.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "rtcs_regs.svh"
module rtcs_refresh_top
   import rtcs_pkg::*;
#(
   parameter int NUM_SELECT = 8
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  standby,
   input  wire logic [7:0]            regAddr,
   input  wire logic [15:0]           regWrData,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   output logic [15:0]                regRdData,
   input  wire logic                  accessValid,
   input  wire logic [28:0]           accessAddr,
   input  wire logic                  refreshDone,
   output logic                       refreshReq,
   output logic                       compareIrq,
   output logic                       overflowIrq,
   output logic [NUM_SELECT-1:0]      memSelectN
);
   ////////////////////////////////////////////////////////////////////
   // State.
   logic [7:0]       intervalCount;
   logic [7:0]       intervalConst;
   logic [9:0]       refreshCount;
   logic             compare_match_flag;
   logic             cmfClearArmed;
   logic             compare_match_irq_enable;
   logic [2:0]       clockSelect;
   logic             ovf;
   logic             refresh_overflow_irq_enable;
   logic             limitSelect;
   logic             refreshEnable;
   logic             refreshModeSelf;
   logic             tick;
   logic             match;
   logic             autoRefresh;
   logic             refreshEvent;
   logic [10:0]      limit;
   logic             keyByteOk;
   logic             keyCountOk;
   logic             wrCtrl;
   logic             wrCnt;
   logic             wrConst;
   logic             wrRCount;
   logic             wrMemCtrl;
   logic [NUM_SELECT-1:0] wrSel;
   logic [15:0]      selValue [NUM_SELECT];
   logic [15:0]      next_rdData;
   rtcs_rstate_t     rstate;

   ////////////////////////////////////////////////////////////////////
   // Write decode with key check.
   assign keyByteOk  = (regWrData[15:8] == `RTCS_KEY8);
   assign keyCountOk = (regWrData[15:10] == `RTCS_KEY6);
   assign wrCtrl   = regWrite && (regAddr == `RTCS_ADDR_CTRL)
                     && keyByteOk;
   assign wrCnt    = regWrite && (regAddr == `RTCS_ADDR_CNT)
                     && keyByteOk;
   assign wrConst  = regWrite && (regAddr == `RTCS_ADDR_CONST)
                     && keyByteOk;
   assign wrRCount = regWrite && (regAddr == `RTCS_ADDR_RCOUNT)
                     && keyCountOk;
   assign wrMemCtrl = regWrite && (regAddr == `RTCS_ADDR_MEMCTRL);

   // Select register strobes, one per window.
   always_comb begin
      for (int i = 0; i < NUM_SELECT; i++) begin
         wrSel[i] = regWrite && (regAddr == 8'(`RTCS_ADDR_MSEL0
                    + i * `RTCS_ADDR_MSEL_STEP));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interval counter and compare.
   assign match = (intervalCount == intervalConst);
   assign autoRefresh = refreshEnable && !refreshModeSelf;
   assign limit = limitSelect ? `RTCS_LIMIT_SHORT
                              : `RTCS_LIMIT_LONG;

   rtcs_prescaler u_prescaler (
      .mclk        (mclk),
      .rst         (rst),
      .hold        (standby),
      .clockSelect (clockSelect),
      .tick        (tick)
   );

   // Counts on prescaler ticks, clears on match; holds in standby.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         intervalCount <= 8'h00;
      end else if (wrCnt) begin
         intervalCount <= regWrData[7:0];
      end else if (!standby && match && clockSelect != 3'd0) begin
         intervalCount <= 8'h00;
      end else if (tick) begin
         intervalCount <= intervalCount + 8'h01;
      end
   end

   // Constant register.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         intervalConst <= 8'h00;
      end else if (wrConst) begin
         intervalConst <= regWrData[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control bits; writing 1 to a flag does nothing.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         compare_match_irq_enable        <= 1'b0;
         clockSelect <= 3'd0;
         refresh_overflow_irq_enable        <= 1'b0;
         limitSelect <= 1'b0;
      end else if (wrCtrl) begin
         compare_match_irq_enable        <= regWrData[`RTCS_COMPARE_MATCH_IRQ_ENABLE_BIT];
         clockSelect <= regWrData[`RTCS_CKS_LSB +: 3];
         refresh_overflow_irq_enable        <= regWrData[`RTCS_REFRESH_OVERFLOW_IRQ_ENABLE_BIT];
         limitSelect <= regWrData[`RTCS_REFRESH_LIMIT_SELECT_BIT];
      end
   end

   // Memory control: refresh enable and refresh mode.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         refreshEnable   <= 1'b0;
         refreshModeSelf <= 1'b0;
      end else if (wrMemCtrl) begin
         refreshEnable   <= regWrData[`RTCS_MEMORY_REFRESH_ENABLE_BIT];
         refreshModeSelf <= regWrData[`RTCS_RMODE_BIT];
      end
   end

   // Compare flag: set wins; clears on refresh after a 0 write.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         compare_match_flag           <= 1'b0;
         cmfClearArmed <= 1'b0;
      end else if (match && clockSelect != 3'd0 && !standby) begin
         compare_match_flag           <= 1'b1;
         cmfClearArmed <= 1'b0;
      end else if (wrCtrl && !regWrData[`RTCS_CMF_BIT] && compare_match_flag) begin
         cmfClearArmed <= 1'b1;
      end else if (cmfClearArmed && refreshEvent && autoRefresh) begin
         compare_match_flag           <= 1'b0;
         cmfClearArmed <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Refresh request handshake to the command sequencer.
   assign refreshEvent = (rstate == RTCS_BUSY) && refreshDone;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rstate <= RTCS_IDLE;
      end else begin
         case (rstate)
            RTCS_IDLE: begin
               if (autoRefresh && match && clockSelect != 3'd0
                   && !standby) begin
                  rstate <= RTCS_REQ;
               end
            end
            RTCS_REQ:  rstate <= RTCS_BUSY;
            RTCS_BUSY: begin
               if (refreshDone) begin
                  rstate <= RTCS_IDLE;
               end
            end
            default:   rstate <= RTCS_IDLE;
         endcase
      end
   end
   assign refreshReq = (rstate == RTCS_REQ);

   // Refresh count and overflow flag; set wins over a 0 write.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         refreshCount <= 10'h000;
         ovf          <= 1'b0;
      end else begin
         if (wrRCount) begin
            refreshCount <= regWrData[9:0];
         end else if (refreshEvent) begin
            if ({1'b0, refreshCount} + 11'h001 >= limit) begin
               refreshCount <= 10'h000;
            end else begin
               refreshCount <= refreshCount + 10'h001;
            end
         end
         if (refreshEvent && !wrRCount
             && ({1'b0, refreshCount} + 11'h001 >= limit)) begin
            ovf <= 1'b1;
         end else if (wrCtrl && !regWrData[`RTCS_OVF_BIT]) begin
            ovf <= 1'b0;
         end
      end
   end

   assign overflowIrq = ovf && refresh_overflow_irq_enable;
   assign compareIrq  = compare_match_flag && compare_match_irq_enable;

   ////////////////////////////////////////////////////////////////////
   // Memory select windows.
   for (genvar g = 0; g < NUM_SELECT; g++) begin : g_win
      rtcs_window_decode u_win (
         .mclk        (mclk),
         .rst         (rst),
         .wrEn        (wrSel[g]),
         .wrData      (regWrData[6:0]),
         .accessValid (accessValid),
         .accessAddr  (accessAddr),
         .ctrlValue   (selValue[g]),
         .memSelectN  (memSelectN[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux; undefined bits read zero, unmapped reads zero.
   always_comb begin
      next_rdData = 16'h0000;
      if (regAddr == `RTCS_ADDR_CTRL) begin
         next_rdData = {8'h00, compare_match_flag, compare_match_irq_enable, clockSelect, ovf, refresh_overflow_irq_enable,
                        limitSelect};
      end else if (regAddr == `RTCS_ADDR_CNT) begin
         next_rdData = {8'h00, intervalCount};
      end else if (regAddr == `RTCS_ADDR_CONST) begin
         next_rdData = {8'h00, intervalConst};
      end else if (regAddr == `RTCS_ADDR_RCOUNT) begin
         next_rdData = {6'h00, refreshCount};
      end else if (regAddr == `RTCS_ADDR_MEMCTRL) begin
         next_rdData = {14'h0000, refreshModeSelf, refreshEnable};
      end else begin
         for (int i = 0; i < NUM_SELECT; i++) begin
            if (regAddr == 8'(`RTCS_ADDR_MSEL0
                + i * `RTCS_ADDR_MSEL_STEP)) begin
               next_rdData = selValue[i];
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         regRdData <= `RTCS_RESET16;
      end else if (regRead) begin
         regRdData <= next_rdData;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_badKey;
      regWrite && regAddr == `RTCS_ADDR_CONST && !keyByteOk;
   endsequence

   // A refresh that takes the count past the short limit.
   sequence s_shortWrap;
      refreshEvent && !wrRCount && limitSelect && refreshCount == 10'h1FF;
   endsequence

   chk_key_guard: assert property (
      @(posedge mclk) disable iff (rst)
      s_badKey |=> $stable(intervalConst))
      else $error("constant changed on bad key");
   chk_count_key: assert property (
      @(posedge mclk) disable iff (rst)
      (regWrite && regAddr == `RTCS_ADDR_RCOUNT && !keyCountOk
       && !refreshEvent) |=> $stable(refreshCount))
      else $error("refresh count changed on bad key");
   chk_ovf_irq: assert property (
      @(posedge mclk) disable iff (rst)
      (wrCtrl && !regWrData[`RTCS_REFRESH_OVERFLOW_IRQ_ENABLE_BIT]) |=> !overflowIrq)
      else $error("overflow irq after enable cleared");
   chk_ovf_one: assert property (
      @(posedge mclk) disable iff (rst)
      (wrCtrl && regWrData[`RTCS_OVF_BIT] && !refreshEvent)
      |=> ovf == $past(ovf))
      else $error("overflow flag changed on a one write");
   chk_ovf_set: assert property (
      @(posedge mclk) disable iff (rst)
      (refreshEvent && !wrRCount && refreshCount == 10'h3FF
       && !limitSelect) |=> ovf && refreshCount == 10'h000)
      else $error("overflow not taken at limit");
   chk_short_limit: assert property (
      @(posedge mclk) disable iff (rst)
      s_shortWrap |=> ovf && refreshCount == 10'h000)
      else $error("overflow not taken at short limit");
   chk_match_clear: assert property (
      @(posedge mclk) disable iff (rst)
      (match && clockSelect != 3'd0 && !standby && !wrCnt)
      |=> compare_match_flag && intervalCount == 8'h00)
      else $error("match did not set flag and clear");
   chk_refresh_start: assert property (
      @(posedge mclk) disable iff (rst)
      (rstate == RTCS_IDLE && autoRefresh && match && !standby
       && clockSelect != 3'd0) |=> refreshReq ##1 !refreshReq)
      else $error("refresh request not issued");
   chk_stop_clock: assert property (
      @(posedge mclk) disable iff (rst)
      (clockSelect == 3'd0 && !wrCnt) |=> $stable(intervalCount))
      else $error("counter moved while stopped");
   chk_cmf_irq: assert property (
      @(posedge mclk) disable iff (rst)
      (wrCtrl && !regWrData[`RTCS_COMPARE_MATCH_IRQ_ENABLE_BIT]) |=> !compareIrq)
      else $error("compare irq after enable cleared");
   chk_standby_hold: assert property (
      @(posedge mclk) disable iff (rst)
      (standby && !wrCnt) [*2] |-> $stable(intervalCount))
      else $error("counter moved in standby");
endmodule : rtcs_refresh_top

// file: rtl/rtcs_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH
`define RTCS_ADDR_CTRL      8'h00
`define RTCS_ADDR_CNT       8'h04
`define RTCS_ADDR_CONST     8'h08
`define RTCS_ADDR_RCOUNT    8'h0C
`define RTCS_ADDR_MEMCTRL   8'h10
`define RTCS_ADDR_MSEL0     8'h20
`define RTCS_ADDR_MSEL_STEP 8'h04
`define RTCS_KEY8           8'hA5
`define RTCS_KEY6           6'h29
`define RTCS_CMF_BIT        7
`define RTCS_COMPARE_MATCH_IRQ_ENABLE_BIT       6
`define RTCS_CKS_LSB        3
`define RTCS_OVF_BIT        2
`define RTCS_REFRESH_OVERFLOW_IRQ_ENABLE_BIT       1
`define RTCS_REFRESH_LIMIT_SELECT_BIT       0
`define RTCS_MEMORY_REFRESH_ENABLE_BIT       0
`define RTCS_RMODE_BIT      1
`define RTCS_LIMIT_LONG     11'h0400
`define RTCS_LIMIT_SHORT    11'h0200
`define RTCS_AREA_BIT       6
`define RTCS_SIZE_LSB       4
`define RTCS_RESET16        16'h0000
`define RTCS_REFRESH_CYCLES 4'h4
`endif

// file: rtl/rtcs_pkg.sv
// Types shared by the refresh timer and memory select logic.
package rtcs_pkg;
   typedef enum logic [1:0] {
      RTCS_IDLE = 2'b00,
      RTCS_REQ  = 2'b01,
      RTCS_BUSY = 2'b11
   } rtcs_rstate_t;
   typedef logic [15:0] rtcs_word_t;
endpackage : rtcs_pkg

// file: rtl/rtcs_prescaler.sv
// Bus clock prescaler giving the interval counter its count enable.
`timescale 1ns/1ps
`include "rtcs_regs.svh"
module rtcs_prescaler
   import rtcs_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       hold,
   input  wire logic [2:0] clockSelect,
   output logic            tick
);
   logic [11:0] divCount;
   logic        sel;

   // Free running divider; frozen while the chip is in standby.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         divCount <= 12'h000;
      end else if (!hold) begin
         divCount <= divCount + 12'h001;
      end
   end

   // Pick the ratio: 4, 16, 64, 256, 1024, 2048 or 4096; 000 stops it.
   always_comb begin
      case (clockSelect)
         3'd1:    sel = (divCount[1:0] == 2'h3);
         3'd2:    sel = (divCount[3:0] == 4'hF);
         3'd3:    sel = (divCount[5:0] == 6'h3F);
         3'd4:    sel = (divCount[7:0] == 8'hFF);
         3'd5:    sel = (divCount[9:0] == 10'h3FF);
         3'd6:    sel = (divCount[10:0] == 11'h7FF);
         3'd7:    sel = (divCount == 12'hFFF);
         default: sel = 1'b0;
      endcase
      tick = sel && !hold;
   end
endmodule : rtcs_prescaler

// file: rtl/rtcs_window_decode.sv
// One memory select window decoder with its own control register.
`timescale 1ns/1ps
`include "rtcs_regs.svh"
module rtcs_window_decode
   import rtcs_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        wrEn,
   input  wire logic [6:0]  wrData,
   input  wire logic        accessValid,
   input  wire logic [28:0] accessAddr,
   output logic [15:0]      ctrlValue,
   output logic             memSelectN
);
   logic [6:0] ctrl;
   logic [2:0] area;
   logic [3:0] mask;
   logic       hit;

   // Only bits 6..0 are stored; the rest read as zero.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= 7'h00;
      end else if (wrEn) begin
         ctrl <= wrData;
      end
   end

   // Area 0 or area 2, window size from 4 MB up to 32 MB.
   always_comb begin
      area = ctrl[`RTCS_AREA_BIT] ? 3'b010 : 3'b000;
      case (ctrl[5:4])
         2'b00:   mask = 4'hF;
         2'b01:   mask = 4'hE;
         2'b10:   mask = 4'hC;
         default: mask = 4'h8;
      endcase
      hit = accessValid && (accessAddr[28:26] == area)
         && ((accessAddr[25:22] & mask) == (ctrl[3:0] & mask));
      ctrlValue = {9'h000, ctrl};
   end

   // Registered active-low select output.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         memSelectN <= 1'b1;
      end else begin
         memSelectN <= !hit;
      end
   end
endmodule : rtcs_window_decode

// file: tb/rtcs_mem_partner.sv
// Far-side model: refresh sequencer and memory answering refresh requests.
`timescale 1ns/1ps
module rtcs_mem_partner (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       refreshReq,
   input  wire logic [7:0] memSelectN,
   output logic            refreshDone,
   output int              doneCount,
   output int              selCount
);
   int   waitLeft;
   logic slow;
   // Each request is answered after one or six cycles, alternately.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         waitLeft    <= 0;
         slow        <= 1'b0;
         refreshDone <= 1'b0;
         doneCount   <= 0;
      end else begin
         refreshDone <= 1'b0;
         if (refreshReq) begin
            waitLeft <= slow ? 6 : 1;
            slow     <= !slow;
         end else if (waitLeft == 1) begin
            refreshDone <= 1'b1;
            doneCount   <= doneCount + 1;
            waitLeft    <= 0;
         end else if (waitLeft > 1) begin
            waitLeft <= waitLeft - 1;
         end
      end
   end

   // All eight pins serve as select outputs; count cycles with any chip selected.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         selCount <= 0;
      end else if (memSelectN != 8'hFF) begin
         selCount <= selCount + 1;
      end
   end
endmodule : rtcs_mem_partner

// file: tb/tb.sv
// Self-checking bench for the refresh timer and memory select block.
`timescale 1ns/1ps
`include "rtcs_regs.svh"
module tb;
   import rtcs_pkg::*;
   logic        mclk, rst, standby, regWrite, regRead, accessValid;
   logic        refreshDone, refreshReq, compareIrq, overflowIrq;
   logic [7:0]  regAddr, memSelectN;
   logic [15:0] regWrData, regRdData, d;
   logic [28:0] accessAddr;
   int          failCount, comparisons, doneCount, cycles, n, lim, mdl [8];
   int          selCount;

   rtcs_refresh_top i_rtcs_refresh_top (.mclk(mclk), .rst(rst),
      .standby(standby), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .accessValid(accessValid), .accessAddr(accessAddr),
      .refreshDone(refreshDone), .refreshReq(refreshReq),
      .compareIrq(compareIrq), .overflowIrq(overflowIrq),
      .memSelectN(memSelectN));
   rtcs_mem_partner i_rtcs_mem_partner (.mclk(mclk), .rst(rst),
      .refreshReq(refreshReq), .memSelectN(memSelectN),
      .refreshDone(refreshDone), .doneCount(doneCount),
      .selCount(selCount));

   ////////////////////////////////////////////////////////////////////////
   // Clock generation.
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Hang guard: the whole run needs well under this many cycles.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks.
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failCount++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task automatic wr(logic [7:0] a, logic [15:0] v);
      @(posedge mclk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= v;
      @(posedge mclk);
      regWrite  <= 1'b0;
      // Let the write land before the caller looks at any output.
      #1;
   endtask : wr

   task automatic rd(logic [7:0] a, output logic [15:0] v);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask : rd

   task automatic waitDone(int target);
      int k;
      k = 0;
      while (doneCount < target && k < 2000) begin
         @(posedge mclk);
         k++;
      end
      chk("refresh answered", 16'(doneCount >= target), 16'h0001);
   endtask : waitDone

   // Reference decode of all eight windows, active low.
   function automatic logic [7:0] selExp(logic [28:0] a);
      logic [7:0] r;
      logic [3:0] m;
      int         v;
      r = 8'hFF;
      for (int j = 0; j < 8; j++) begin
         v = mdl[j];
         m = 4'hF << v[5:4];
         if (a[28:26] == (v[6] ? 3'b010 : 3'b000) &&
             ((a[25:22] ^ v[3:0]) & m) == 4'h0)
            r[j] = 1'b0;
      end
      return r;
   endfunction : selExp

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      int a, v, j;
      rst = 1'b1; standby = 1'b0; regWrite = 1'b0; regRead = 1'b0;
      regAddr = 8'h00; regWrData = 16'h0000; accessValid = 1'b0;
      accessAddr = 29'h0000_0000; failCount = 0; comparisons = 0; cycles = 0;
      void'($urandom(32'hf6774886));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      // Reset values, then an unmapped address.
      for (int k = 0; k < 13; k++) begin
         a = k < 4 ? k * 4 : (k < 12 ? 32 + (k - 4) * 4 : 64);
         rd(8'(a), d);
         chk("reset value", d, 16'h0000);
      end
      // Compare match in self-refresh mode (no auto-refresh): flag sets and stays.
      wr(`RTCS_ADDR_CONST, 16'hA502);
      wr(`RTCS_ADDR_MEMCTRL, 16'h0003);
      n = doneCount;
      wr(`RTCS_ADDR_CTRL, 16'hA548);
      for (int k = 0; k < 200 && compareIrq !== 1'b1; k++) @(posedge mclk);
      chk("compare irq", 16'(compareIrq), 16'h0001);
      wr(`RTCS_ADDR_CTRL, 16'hA540);
      rd(`RTCS_ADDR_CTRL, d);
      chk("ctrl after cmf zero", d, 16'h00C0);
      chk("no refresh", 16'(doneCount - n), 16'h0000);
      wr(`RTCS_ADDR_CTRL, 16'hA580);
      chk("compare irq masked", 16'(compareIrq), 16'h0000);
      // Keyed counter and constant writes; bad keys ignored.
      wr(`RTCS_ADDR_CNT, 16'hA537);
      wr(`RTCS_ADDR_CNT, 16'h5A11);
      rd(`RTCS_ADDR_CNT, d);
      chk("interval counter", d, 16'h0037);
      wr(`RTCS_ADDR_CONST, 16'h5A99);
      rd(`RTCS_ADDR_CONST, d);
      chk("constant", d, 16'h0002);
      // Refresh count overflow at both limits.
      for (int lm = 0; lm < 2; lm++) begin
         lim = lm ? 512 : 1024;
         wr(`RTCS_ADDR_CTRL, 16'hA500 | 16'(lm));
         wr(`RTCS_ADDR_CONST, 16'hA5C8);
         wr(`RTCS_ADDR_MEMCTRL, 16'h0001);
         rd(`RTCS_ADDR_MEMCTRL, d);
         chk("memory control", d, 16'h0001);
         wr(`RTCS_ADDR_RCOUNT, 16'h5C00 | 16'(lim - 1));
         wr(`RTCS_ADDR_RCOUNT, 16'hA400 | 16'(lim - 1));
         rd(`RTCS_ADDR_RCOUNT, d);
         chk("refresh count", d, 16'(lim - 1));
         n = doneCount;
         wr(`RTCS_ADDR_CTRL, 16'hA50A | 16'(lm));
         waitDone(n + 1);
         wr(`RTCS_ADDR_CTRL, 16'hA586 | 16'(lm));
         rd(`RTCS_ADDR_CTRL, d);
         chk("ovf set", d & 16'hFF7F, 16'h0006 | 16'(lm));
         rd(`RTCS_ADDR_RCOUNT, d);
         chk("count wrapped", d, 16'h0000);
         chk("overflow irq", 16'(overflowIrq), 16'h0001);
         wr(`RTCS_ADDR_CTRL, 16'hA582 | 16'(lm));
         chk("ovf cleared", 16'(overflowIrq), 16'h0000);
      end
      // Standby freezes a running interval counter.
      wr(`RTCS_ADDR_CTRL, 16'hA508);
      @(posedge mclk);
      standby <= 1'b1;
      rd(`RTCS_ADDR_CNT, d);
      v = d;
      repeat (40) @(posedge mclk);
      rd(`RTCS_ADDR_CNT, d);
      chk("standby hold", d, 16'(v));
      @(posedge mclk);
      standby <= 1'b0;
      wr(`RTCS_ADDR_CTRL, 16'hA500);
      // Random select windows and accesses against the reference decode.
      for (int k = 0; k < 60; k++) begin
         j = $urandom_range(7);
         v = $urandom & 32'h7F;
         if (j == 0) v = v & 32'hBF;
         wr(8'(32 + j * 4), 16'(v));
         mdl[j] = v & 32'h7F;
         rd(8'(32 + j * 4), d);
         chk("select ctrl", d, 16'(mdl[j]));
         j = $urandom_range(7);
         a = {mdl[j][6] ? 3'b010 : 3'b000, 4'(mdl[j]), 22'($urandom)};
         if ($urandom_range(1)) a = $urandom & 32'h1FFF_FFFF;
         @(posedge mclk);
         accessValid <= 1'b1;
         accessAddr  <= 29'(a);
         @(posedge mclk);
         accessValid <= 1'b0;
         #1 d = 16'(selExp(29'(a)));
         chk("selects", 16'(memSelectN), d);
      end
      chk("selects seen", 16'(selCount > 0), 16'h0001);
      close_out();
   end
endmodule : tb
